// file: rtl/wtw_cfg.svh
// timing and width constants for the wake-up timer watchdog
`ifndef WTW_CFG_SVH
`define WTW_CFG_SVH

`define WTW_CLK_PERIOD_NS   5
`define WTW_OSC_PERIOD_MS   10
`define WTW_TICK_CYCLES     ((`WTW_OSC_PERIOD_MS * 1000000) / `WTW_CLK_PERIOD_NS)
`define WTW_TICK_CNT_W      21

`define WTW_ALERT_MS        20
`define WTW_ALERT_TICKS     ((`WTW_ALERT_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_RST_PULSE_MS    320
`define WTW_RST_TICKS       ((`WTW_RST_PULSE_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_ACK_WIN_MS      20
`define WTW_ACK_TICKS       ((`WTW_ACK_WIN_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_DEBOUNCE_MS     20
`define WTW_DB_TICKS        ((`WTW_DEBOUNCE_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_MEAS_MS         100
`define WTW_MEAS_TICKS      ((`WTW_MEAS_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)

`define WTW_IVL_W           20
`define WTW_IVL_MIN_MS      100
`define WTW_IVL_MAX_S       7200
`define WTW_IVL_MIN_TICKS   (`WTW_IVL_MIN_MS / `WTW_OSC_PERIOD_MS)
`define WTW_IVL_MAX_TICKS   ((`WTW_IVL_MAX_S * 1000) / `WTW_OSC_PERIOD_MS)
`define WTW_PH_W            6
`define WTW_PIN_HIST_W      3

`endif

// file: rtl/wtw_pkg.sv
// types shared by the wake-up timer watchdog modules
package wtw_pkg;

   typedef enum logic [2:0] {
      WTW_MEAS,
      WTW_RUN,
      WTW_RSTPULSE,
      WTW_MRST,
      WTW_DEBOUNCE
   } wtw_state_t;

   // conditioned inputs; tick, mr_high and mr_low on the oscillator tick grid, ack_rise on every clock
   typedef struct packed {
      logic tick;
      logic ack_rise;
      logic mr_high;
      logic mr_low;
   } wtw_samp_t;

endpackage : wtw_pkg

// file: rtl/wtw_sampler.sv
// oscillator tick divider and input conditioning for the watchdog
`include "wtw_cfg.svh"
module wtw_sampler
   import wtw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `WTW_TICK_CYCLES
) (
   input  wire logic      core_clk,
   input  wire logic      rst,
   input  wire logic      clr,
   input  wire logic      host_ack,
   input  wire logic      mrst_pin,
   output wtw_samp_t      samp
);

   logic [`WTW_TICK_CNT_W-1:0] div_cnt;
   logic [`WTW_TICK_CNT_W-1:0] next_div_cnt;
   logic                       ack_s1;
   logic                       ack_s2;
   logic                       ack_s3;
   logic                       pin_s1;
   logic                       pin_s2;
   logic [`WTW_PIN_HIST_W-1:0] pin_hist;
   logic [`WTW_PIN_HIST_W-1:0] next_pin_hist;
   wtw_samp_t                  next_samp;
   logic                       tick;

   assign tick = (div_cnt == `WTW_TICK_CNT_W'(TICK_CYCLES - 1));

   // divider and tick-grid sampling of the shared pin
   always_comb begin
      next_div_cnt  = (tick || clr) ? '0 : div_cnt + `WTW_TICK_CNT_W'(1);
      next_pin_hist = pin_hist;
      if (clr) begin
         next_pin_hist = '0;
      end else if (tick) begin
         next_pin_hist = {pin_hist[`WTW_PIN_HIST_W-2:0], pin_s2};
      end
      next_samp.tick     = tick && !clr;
      next_samp.ack_rise = ack_s2 && !ack_s3;
      // two high samples in a row: the two latest of the three-tick history
      next_samp.mr_high  = (next_pin_hist[1:0] == 2'h3);
      next_samp.mr_low   = !next_pin_hist[0];
   end

   // pin synchroniser feeds only its second stage, the ack edge uses the second and third stages
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt  <= '0;
         ack_s1   <= 1'b0;
         ack_s2   <= 1'b0;
         ack_s3   <= 1'b0;
         pin_s1   <= 1'b0;
         pin_s2   <= 1'b0;
         pin_hist <= '0;
         samp     <= '0;
      end else begin
         div_cnt  <= next_div_cnt;
         ack_s1   <= host_ack;
         ack_s2   <= ack_s1;
         ack_s3   <= ack_s2;
         pin_s1   <= mrst_pin;
         pin_s2   <= pin_s1;
         pin_hist <= next_pin_hist;
         samp     <= next_samp;
      end
   end

endmodule : wtw_sampler

// file: rtl/wtw_top.sv
// wake-up timer with watchdog: interval, alert, ack and reset sequencing
`include "wtw_cfg.svh"
module wtw_top
   import wtw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `WTW_TICK_CYCLES
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  host_ack,
   input  wire logic                  mrst_pin,
   input  wire logic [`WTW_IVL_W-1:0] meas_ticks,
   output logic                       meas_active,
   output logic                       periodic_alert,
   output logic                       host_reset_n
);

   wtw_samp_t             samp;
   wtw_state_t            state;
   wtw_state_t            next_state;
   logic [`WTW_IVL_W-1:0] interval;
   logic [`WTW_IVL_W-1:0] next_interval;
   logic [`WTW_IVL_W-1:0] int_cnt;
   logic [`WTW_IVL_W-1:0] next_int_cnt;
   logic [`WTW_PH_W-1:0]  ph_cnt;
   logic [`WTW_PH_W-1:0]  next_ph_cnt;
   logic [`WTW_PH_W-1:0]  alert_cnt;
   logic [`WTW_PH_W-1:0]  next_alert_cnt;
   logic                  acked;
   logic                  next_acked;
   logic                  meas_pending;
   logic                  next_meas_pending;
   logic                  next_alert;
   logic                  next_reset_n;
   logic                  mr_valid;
   logic                  int_end;
   logic                  ack_take;

   // clamp the converted interval into the selectable range
   function automatic logic [`WTW_IVL_W-1:0] clamp_ivl(input logic [`WTW_IVL_W-1:0] v);
      if (v < `WTW_IVL_W'(`WTW_IVL_MIN_TICKS)) begin
         return `WTW_IVL_W'(`WTW_IVL_MIN_TICKS);
      end else if (v > `WTW_IVL_W'(`WTW_IVL_MAX_TICKS)) begin
         return `WTW_IVL_W'(`WTW_IVL_MAX_TICKS);
      end
      return v;
   endfunction : clamp_ivl

   // tick generator and input conditioning
   wtw_sampler #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_sampler (
      .core_clk (core_clk),
      .rst      (rst),
      .clr      (mr_valid),
      .host_ack (host_ack),
      .mrst_pin (mrst_pin),
      .samp     (samp)
   );

   // event decode
   assign mr_valid = samp.mr_high && (state != WTW_MRST) && (state != WTW_DEBOUNCE);
   assign int_end  = (state == WTW_RUN) && samp.tick && (int_cnt == interval - `WTW_IVL_W'(1));
   // edge counts once, during the reset pulse or before the last ack window of the interval
   assign ack_take = samp.ack_rise && !acked && !mr_valid &&
      ((state == WTW_RSTPULSE) ||
       ((state == WTW_RUN) && (int_cnt < interval - `WTW_IVL_W'(`WTW_ACK_TICKS))));

   // sequencing of measurement, run, reset pulse and manual reset
   always_comb begin
      next_state        = state;
      next_interval     = interval;
      next_int_cnt      = int_cnt;
      next_ph_cnt       = ph_cnt;
      next_acked        = acked;
      next_meas_pending = meas_pending;
      if (ack_take) begin
         next_acked = 1'b1;
      end
      if (mr_valid) begin
         // clear counters and ack, keep the interval, remember an aborted measurement
         next_state   = WTW_MRST;
         next_int_cnt = '0;
         next_ph_cnt  = '0;
         next_acked   = 1'b0;
         if (state == WTW_MEAS) begin
            next_meas_pending = 1'b1;
         end
      end else begin
         unique case (state)
            WTW_MEAS: begin
               if (samp.tick) begin
                  next_ph_cnt = ph_cnt + `WTW_PH_W'(1);
                  if (ph_cnt == `WTW_PH_W'(`WTW_MEAS_TICKS - 1)) begin
                     next_interval     = clamp_ivl(meas_ticks);
                     next_meas_pending = 1'b0;
                     next_ph_cnt       = '0;
                     next_int_cnt      = '0;
                     next_state        = WTW_RUN;
                  end
               end
            end
            WTW_RUN: begin
               if (int_end) begin
                  next_int_cnt = '0;
                  next_acked   = 1'b0;
                  if (!acked) begin
                     next_state = WTW_RSTPULSE;
                  end
               end else if (samp.tick) begin
                  next_int_cnt = int_cnt + `WTW_IVL_W'(1);
               end
            end
            WTW_RSTPULSE: begin
               if (samp.tick) begin
                  next_ph_cnt = ph_cnt + `WTW_PH_W'(1);
                  if (ph_cnt == `WTW_PH_W'(`WTW_RST_TICKS - 1)) begin
                     next_ph_cnt  = '0;
                     next_int_cnt = '0;
                     next_state   = meas_pending ? WTW_MEAS : WTW_RUN;
                  end
               end
            end
            WTW_MRST: begin
               if (samp.tick && samp.mr_low) begin
                  next_state = WTW_DEBOUNCE;
               end
            end
            WTW_DEBOUNCE: begin
               if (samp.tick) begin
                  next_ph_cnt = ph_cnt + `WTW_PH_W'(1);
                  if (!samp.mr_low) begin
                     next_ph_cnt = '0;
                     next_state  = WTW_MRST;
                  end else if (ph_cnt == `WTW_PH_W'(`WTW_DB_TICKS - 1)) begin
                     next_ph_cnt = '0;
                     next_state  = WTW_RSTPULSE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state        <= WTW_MEAS;
         interval     <= `WTW_IVL_W'(`WTW_IVL_MIN_TICKS);
         int_cnt      <= '0;
         ph_cnt       <= '0;
         acked        <= 1'b0;
         meas_pending <= 1'b0;
      end else begin
         state        <= next_state;
         interval     <= next_interval;
         int_cnt      <= next_int_cnt;
         ph_cnt       <= next_ph_cnt;
         acked        <= next_acked;
         meas_pending <= next_meas_pending;
      end
   end

   // output pins
   always_comb begin
      next_alert     = periodic_alert;
      next_alert_cnt = alert_cnt;
      if (mr_valid || ack_take) begin
         next_alert     = 1'b0;
         next_alert_cnt = '0;
      end else if (int_end && acked) begin
         next_alert     = 1'b1;
         next_alert_cnt = '0;
      end else if (periodic_alert && samp.tick) begin
         next_alert_cnt = alert_cnt + `WTW_PH_W'(1);
         if (alert_cnt == `WTW_PH_W'(`WTW_ALERT_TICKS - 1)) begin
            next_alert = 1'b0;
         end
      end
      next_reset_n = (next_state == WTW_RUN);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         periodic_alert <= 1'b0;
         alert_cnt      <= '0;
         host_reset_n   <= 1'b0;
         meas_active    <= 1'b1;
      end else begin
         periodic_alert <= next_alert;
         alert_cnt      <= next_alert_cnt;
         host_reset_n   <= next_reset_n;
         meas_active    <= (next_state == WTW_MEAS);
      end
   end

   // checks
   sequence s_miss;
      int_end && !acked;
   endsequence

   sequence s_hit;
      int_end && acked;
   endsequence

   sequence s_meas_done;
      (state == WTW_MEAS) ##1 (state == WTW_RUN);
   endsequence

   sequence s_pulse_done;
      (state == WTW_RSTPULSE) ##1 (state == WTW_RUN);
   endsequence

   chk_alert_rest: assert property (@(posedge core_clk) disable iff (rst)
      (state != WTW_RUN) |-> !periodic_alert)
      else $error("alert high outside run");

   chk_reset_in_meas: assert property (@(posedge core_clk) disable iff (rst)
      (state == WTW_MEAS) |-> !host_reset_n && meas_active)
      else $error("reset released during measurement");

   chk_alert_on_hit: assert property (@(posedge core_clk) disable iff (rst)
      s_hit ##0 !mr_valid |=> periodic_alert && host_reset_n)
      else $error("no alert after acknowledged interval");

   chk_miss_reset: assert property (@(posedge core_clk) disable iff (rst)
      s_miss ##1 !mr_valid |-> !host_reset_n && !periodic_alert)
      else $error("missed ack did not reset host");

   chk_ack_drops_alert: assert property (@(posedge core_clk) disable iff (rst)
      ack_take && periodic_alert |=> !periodic_alert)
      else $error("alert not dropped on ack");

   chk_ack_keeps_count: assert property (@(posedge core_clk) disable iff (rst)
      ack_take && (state == WTW_RUN) && !samp.tick |=> int_cnt == $past(int_cnt))
      else $error("ack disturbed interval count");

   chk_ack_once: assert property (@(posedge core_clk) disable iff (rst)
      acked && !int_end && !mr_valid |-> !ack_take ##1 acked)
      else $error("second ack acted upon");

   chk_mr_forces: assert property (@(posedge core_clk) disable iff (rst)
      mr_valid |=> !host_reset_n && !periodic_alert && (state == WTW_MRST))
      else $error("manual reset did not force outputs");

   chk_interval_fixed: assert property (@(posedge core_clk) disable iff (rst)
      (state != WTW_MEAS) |=> interval == $past(interval))
      else $error("interval changed outside measurement");

   chk_interval_range: assert property (@(posedge core_clk) disable iff (rst)
      interval >= `WTW_IVL_W'(`WTW_IVL_MIN_TICKS) && interval <= `WTW_IVL_W'(`WTW_IVL_MAX_TICKS))
      else $error("interval out of range");

   chk_meas_length: assert property (@(posedge core_clk) disable iff (rst)
      (state == WTW_MEAS) && samp.tick && !mr_valid &&
      (ph_cnt == `WTW_PH_W'(`WTW_MEAS_TICKS - 1)) |=> host_reset_n && !meas_active)
      else $error("measurement did not end on time");

   chk_pulse_end: assert property (@(posedge core_clk) disable iff (rst)
      (state == WTW_RSTPULSE) && samp.tick && !mr_valid &&
      (ph_cnt == `WTW_PH_W'(`WTW_RST_TICKS - 1)) |=> (state != WTW_RSTPULSE))
      else $error("reset pulse overran");

   chk_alert_hold: assert property (@(posedge core_clk) disable iff (rst)
      periodic_alert && !samp.tick && !ack_take && !mr_valid |=> periodic_alert)
      else $error("alert dropped between ticks");

   chk_late_ack_dropped: assert property (@(posedge core_clk) disable iff (rst)
      samp.ack_rise && (state == WTW_RUN) && !int_end && !mr_valid &&
      (int_cnt >= interval - `WTW_IVL_W'(`WTW_ACK_TICKS)) |=> acked == $past(acked))
      else $error("ack in closing window acted upon");

   chk_mr_hold: assert property (@(posedge core_clk) disable iff (rst)
      (state == WTW_MRST) || (state == WTW_DEBOUNCE) |-> !host_reset_n && !periodic_alert)
      else $error("outputs released during manual reset");

   chk_meas_abort: assert property (@(posedge core_clk) disable iff (rst)
      mr_valid && (state == WTW_MEAS) |=> meas_pending)
      else $error("aborted measurement not remembered");

   chk_first_quiet: assert property (@(posedge core_clk) disable iff (rst)
      s_meas_done |-> !periodic_alert)
      else $error("alert at start of first interval");

   chk_restart_quiet: assert property (@(posedge core_clk) disable iff (rst)
      s_pulse_done |-> !periodic_alert)
      else $error("alert after reset pulse");

   chk_mr_clears: assert property (@(posedge core_clk) disable iff (rst)
      mr_valid |=> (int_cnt == '0) && (ph_cnt == '0) && !acked)
      else $error("manual reset left counters running");

endmodule : wtw_top

// file: verif/wtw_host_model.sv
// host microcontroller model that acknowledges alerts and resets
module wtw_host_model #(
   parameter int ACK_HOLD = 24
) (
   input  wire logic        core_clk,
   input  wire logic [15:0] ack_delay,
   input  wire logic        periodic_alert,
   input  wire logic        host_reset_n,
   output logic             host_ack
);
   timeunit 1ns;
   timeprecision 100ps;

   logic p_al     = 1'b0;
   logic p_rn     = 1'b0;
   int   wait_cnt = 0;
   int   hold_cnt = 0;

   initial host_ack = 1'b0;

   // arm on alert rise or any reset edge, pulse ack once the delay runs out
   always @(posedge core_clk) begin
      p_al <= periodic_alert;
      p_rn <= host_reset_n;
      host_ack <= (hold_cnt > 0);
      if (hold_cnt > 0)
         hold_cnt <= hold_cnt - 1;
      if ((p_al === 1'b0 && periodic_alert === 1'b1) ||
          (p_rn === 1'b1 && host_reset_n === 1'b0) ||
          (p_rn === 1'b0 && host_reset_n === 1'b1))
         wait_cnt <= int'(ack_delay);
      else if (wait_cnt > 0)
         wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1)
         hold_cnt <= ACK_HOLD;
   end
endmodule : wtw_host_model

// file: verif/wakeup_timer_watchdog_bench.sv
// self-checking bench for the wake-up timer watchdog
`include "wtw_cfg.svh"
module wakeup_timer_watchdog_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int TC   = 32;
   localparam int IVL  = `WTW_IVL_MIN_TICKS;
   localparam int ALW  = `WTW_ALERT_TICKS * TC;
   localparam int RSTW = `WTW_RST_TICKS * TC;
   localparam int DB   = `WTW_DB_TICKS * TC;
   localparam int MEAS = `WTW_MEAS_TICKS * TC;
   localparam int IP   = IVL * TC;
   localparam int IVL2 = 12;

   logic        core_clk     = 1'b0;
   logic        rst          = 1'b1;
   logic        mrst_pin     = 1'b0;
   logic [15:0] ack_delay    = 16'h0028;
   logic [`WTW_IVL_W-1:0] meas_val = 20'h00004; // below range, must clamp
   logic        host_ack;
   logic        meas_active;
   logic        periodic_alert;
   logic        host_reset_n;
   logic        p_al         = 1'b0;
   logic        p_rn         = 1'b0;
   int          num_errors   = 0;
   int          total_checks = 0;
   int          cyc          = 0;
   int          n_ev[4]      = '{default: 0};
   int          t_ev[4]      = '{default: 0};

   wtw_top #(.TICK_CYCLES(TC)) i_dut (
      .core_clk       (core_clk),
      .rst            (rst),
      .host_ack       (host_ack),
      .mrst_pin       (mrst_pin),
      .meas_ticks     (meas_val),
      .meas_active    (meas_active),
      .periodic_alert (periodic_alert),
      .host_reset_n   (host_reset_n)
   );

   wtw_host_model i_host (
      .core_clk       (core_clk),
      .ack_delay      (ack_delay),
      .periodic_alert (periodic_alert),
      .host_reset_n   (host_reset_n),
      .host_ack       (host_ack)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic note(input int k);
      n_ev[k] <= n_ev[k] + 1;
      t_ev[k] <= cyc;
   endtask : note

   // event log: 0 alert rise, 1 alert fall, 2 reset fall, 3 reset rise
   always @(posedge core_clk) begin
      cyc  <= cyc + 1;
      p_al <= periodic_alert;
      p_rn <= host_reset_n;
      if (p_al === 1'b0 && periodic_alert === 1'b1)
         note(0);
      if (p_al === 1'b1 && periodic_alert === 1'b0)
         note(1);
      if (p_rn === 1'b1 && host_reset_n === 1'b0)
         note(2);
      if (p_rn === 1'b0 && host_reset_n === 1'b1)
         note(3);
   end

   task automatic check_near(input string what, input int exp, input int seen, input int tol);
      total_checks++;
      if (seen < exp - tol || seen > exp + tol) begin
         num_errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check_near

   task automatic check_bit(input string what, input logic exp, input logic seen);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, seen);
      end
   endtask : check_bit

   // bounded wait for a new logged event, returns on a rising edge
   task automatic wait_ev(input int k, input int lim);
      int old;
      old = n_ev[k];
      for (int i = 0; i < lim && n_ev[k] == old; i++)
         @(posedge core_clk);
      @(negedge core_clk);
      check_near("event count", old + 1, n_ev[k], 0);
      @(posedge core_clk);
   endtask : wait_ev

   task automatic complete_run();
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   task automatic test_startup();
      int t0;
      check_bit("por reset", 1'b0, host_reset_n);
      check_bit("por alert", 1'b0, periodic_alert);
      check_bit("por meas", 1'b1, meas_active);
      rst <= 1'b0;
      t0 = cyc;
      wait_ev(3, MEAS + 4 * TC);
      check_near("measure time", MEAS, t_ev[3] - t0, 4);
      check_bit("meas done", 1'b0, meas_active);
      wait_ev(0, IP + 4 * TC);
      check_near("first alert", IP, t_ev[0] - t_ev[3], 4);
      wait_ev(1, ALW);
      check_near("acked alert width", 46, t_ev[1] - t_ev[0], 6);
   endtask : test_startup

   task automatic test_interval();
      int tp;
      ack_delay <= 16'h0064;
      tp = t_ev[0];
      wait_ev(0, IP);
      check_near("alert spacing", IP, t_ev[0] - tp, 1);
      wait_ev(1, ALW + 4);
      check_near("alert width", ALW, t_ev[1] - t_ev[0], 2);
   endtask : test_interval

   task automatic test_late_ack();
      int na;
      ack_delay <= 16'h012c;
      wait_ev(0, IP);
      na = n_ev[0];
      ack_delay <= 16'h0028;
      wait_ev(2, IP);
      check_near("missed ack reset", IP, t_ev[2] - t_ev[0], 2);
      check_near("alerts on miss", na, n_ev[0], 0);
      wait_ev(3, RSTW + 4);
      check_near("reset width", RSTW, t_ev[3] - t_ev[2], 2);
      wait_ev(0, IP + 8);
      check_near("fall to alert", RSTW + IP, t_ev[0] - t_ev[2], 2);
   endtask : test_late_ack

   task automatic test_mrst();
      int t0;
      int nr;
      wait_ev(1, ALW);
      mrst_pin <= 1'b1;
      repeat (TC - 4) @(posedge core_clk);
      mrst_pin <= 1'b0;
      nr = n_ev[2];
      repeat (3 * TC) @(posedge core_clk);
      check_near("glitch ignored", nr, n_ev[2], 0);
      mrst_pin <= 1'b1;
      t0 = cyc;
      wait_ev(2, 4 * TC);
      check_near("mrst detect", 3 * TC / 2, t_ev[2] - t0, TC / 2 + 6);
      check_bit("alert on mrst", 1'b0, periodic_alert);
      repeat (2 * TC) @(posedge core_clk);
      check_bit("reset held", 1'b0, host_reset_n);
      mrst_pin <= 1'b0;
      t0 = cyc;
      wait_ev(3, DB + RSTW + 4 * TC);
      check_near("mrst release", DB + RSTW + TC / 2, t_ev[3] - t0, TC);
      wait_ev(0, IP + 4 * TC);
      check_near("restart interval", IP, t_ev[0] - t_ev[3], 4);
   endtask : test_mrst

   task automatic test_mrst_meas();
      int t0;
      int tp;
      rst <= 1'b1;
      meas_val <= 20'h0000c;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      mrst_pin <= 1'b1;
      repeat (4 * TC) @(posedge core_clk);
      check_bit("reset in abort", 1'b0, host_reset_n);
      mrst_pin <= 1'b0;
      t0 = cyc;
      wait_ev(3, DB + RSTW + MEAS + 4 * TC);
      check_near("meas restart", DB + RSTW + MEAS + TC / 2, t_ev[3] - t0, TC);
      meas_val <= 20'h00005;
      wait_ev(0, (IVL2 + 4) * TC);
      check_near("learned interval", IVL2 * TC, t_ev[0] - t_ev[3], 4);
      tp = t_ev[0];
      wait_ev(0, IVL2 * TC + 4);
      check_near("fixed interval", IVL2 * TC, t_ev[0] - tp, 1);
   endtask : test_mrst_meas

   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      test_startup();
      test_interval();
      test_late_ack();
      test_mrst();
      test_mrst_meas();
      complete_run();
   end

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      complete_run();
   end
endmodule : wakeup_timer_watchdog_bench
